// ### design/touch_power_state_status_regs.sv
/*
 * Power state control, gain selection and touch status registers of a three-input
 * touch controller, with the active-low alert output.
 * Assumes an SMBus engine on mclk presents decoded single-cycle register strobes, and
 * that the sensing logic supplies event levels and pulses synchronous to mclk.
 */
`timescale 1ns/1ns

module touch_power_state_status_regs #(
  parameter int NUM_INPUTS = 3
) (
  // Clock and reset
  input  wire logic                         mclk,
  input  wire logic                         resetn,
  // Register strobes from the SMBus engine, and read answers to it
  input  wire logic [7:0]                   reg_addr,
  input  wire logic [7:0]                   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [7:0]                   reg_rdata,
  output logic                              reg_rvalid,
  // Per-input configuration and sensing results
  input  wire logic [NUM_INPUTS-1:0]        active_en,
  input  wire logic [NUM_INPUTS-1:0]        standby_en,
  input  wire logic [NUM_INPUTS-1:0]        irq_en,
  input  wire logic [NUM_INPUTS-1:0]        touch_detect,
  // Detector events
  input  wire logic                         base_out_any,
  input  wire logic                         cal_fail_any,
  input  wire logic                         hold_event,
  input  wire logic                         hold_button_touched,
  input  wire logic                         multi_blocking,
  input  wire logic                         pattern_cond,
  input  wire logic                         pattern_irq_en,
  // Outputs to the sensing front end
  output touch_regs_pkg::power_state_t      power_state,
  output logic      [NUM_INPUTS-1:0]        scan_en,
  output logic      [3:0]                   active_gain,
  output logic      [3:0]                   standby_gain,
  output logic                              recal_all,
  output logic      [NUM_INPUTS-1:0]        release_pulse,
  // Alert pin
  output logic                              alert_n
);

  `include "touch_regs_defines.svh"

  // --------------------------------------------------------------------
  // Elaboration check
  // --------------------------------------------------------------------
  // The touch status layout has exactly three input bits.
  if (NUM_INPUTS != 3) begin : g_bad_inputs
    $error("NUM_INPUTS must be 3");
  end

  // --------------------------------------------------------------------
  // Reset synchroniser
  // --------------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]            ctrl;
    logic                  base_limit_flag;
    logic                  cal_failure_flag;
    logic                  hold_button_flag;
    logic                  multi_block_flag;
    logic                  pattern_hit_flag;
    logic [NUM_INPUTS-1:0] touched;
    logic [NUM_INPUTS-1:0] sampled;
    logic [NUM_INPUTS-1:0] release_p;
    logic                  recal;
    logic [7:0]            rdata;
    logic                  rvalid;
  } regs_t;

  regs_t state_q;
  regs_t state_d;

  touch_regs_pkg::power_state_t pstate;
  logic [NUM_INPUTS-1:0]        scan;
  logic [NUM_INPUTS-1:0]        live_touch;
  logic                         ctrl_wr;
  logic                         irq_clear;
  logic                         irq_set;
  logic [7:0]                   gen_status;
  logic [7:0]                   input_status;

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  // Everything below reads only the registered copy, so a write and an event in the
  // same cycle both see the state from before that edge.
  always_comb begin
    // ------------------------------------------------------------------
    // Power state and scan set
    // ------------------------------------------------------------------
    // State priority resolve
    if (state_q.ctrl[`CTL_DEEP_SLEEP]) begin
      pstate = touch_regs_pkg::PWR_DEEP;
    end else if (state_q.ctrl[`CTL_MIXED]) begin
      pstate = touch_regs_pkg::PWR_MIXED;
    end else if (state_q.ctrl[`CTL_STANDBY]) begin
      pstate = touch_regs_pkg::PWR_STANDBY;
    end else begin
      pstate = touch_regs_pkg::PWR_ACTIVE;
    end

    case (pstate)
      touch_regs_pkg::PWR_ACTIVE:  scan = active_en;
      touch_regs_pkg::PWR_STANDBY: scan = standby_en;
      touch_regs_pkg::PWR_MIXED:   scan = active_en | standby_en;
      default:                     scan = '0;
    endcase

    live_touch = touch_detect & scan;

    // ------------------------------------------------------------------
    // Status views
    // ------------------------------------------------------------------
    // Any-touch summary
    input_status = {{(8 - NUM_INPUTS){1'b0}}, state_q.touched};
    gen_status = 8'h00;
    gen_status[`GST_BASE_LIMIT] = state_q.base_limit_flag;
    gen_status[`GST_CAL_FAIL]   = state_q.cal_failure_flag;
    gen_status[`GST_HOLD]       = state_q.hold_button_flag;
    gen_status[`GST_MULTI]      = state_q.multi_block_flag;
    gen_status[`GST_PATTERN]    = state_q.pattern_hit_flag;
    gen_status[`GST_ANY_TOUCH]  = |state_q.touched;

    // ------------------------------------------------------------------
    // Pending flag and control write
    // ------------------------------------------------------------------
    ctrl_wr = reg_wr && (reg_addr == `OFS_POWER_GAIN_CONTROL);
    // Host clears pending with a zero
    // A zero written while nothing is pending still clears resolved status; otherwise a
    // touch that outlived the last clear could never be released from its status bit.
    irq_clear = ctrl_wr && !reg_wdata[`CTL_IRQ];

    // Enabled new touches, hold events and enabled new pattern hits raise pending
    irq_set = (|(live_touch & ~state_q.touched & irq_en))
            || hold_event
            || (pattern_cond && !state_q.pattern_hit_flag && pattern_irq_en);

    state_d = state_q;
    state_d.rvalid    = reg_rd;
    state_d.recal     = 1'b0;
    state_d.sampled   = scan;
    state_d.release_p = state_q.sampled & ~scan;

    if (ctrl_wr) begin
      // Pending bit clears only by a host write of zero or in deep sleep; a written one leaves it alone.
      state_d.ctrl = {reg_wdata[7:1], state_q.ctrl[`CTL_IRQ]};
      state_d.recal = (reg_wdata[`CTL_GAIN_HI:`CTL_GAIN_LO]
                       != state_q.ctrl[`CTL_GAIN_HI:`CTL_GAIN_LO])
                   || (reg_wdata[`CTL_SGAIN_HI:`CTL_SGAIN_LO]
                       != state_q.ctrl[`CTL_SGAIN_HI:`CTL_SGAIN_LO]);
    end

    // A new event in the clearing cycle wins, so no interrupt is lost.
    if (irq_set) begin
      state_d.ctrl[`CTL_IRQ] = 1'b1;
    end else if (irq_clear) begin
      state_d.ctrl[`CTL_IRQ] = 1'b0;
    end

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    // Base limit follows detector
    state_d.base_limit_flag  = base_out_any;
    state_d.cal_failure_flag = cal_fail_any;
    state_d.multi_block_flag = multi_blocking;

    // Hold flag set and conditional clear
    if (hold_event) begin
      state_d.hold_button_flag = 1'b1;
    end else if (irq_clear && !hold_button_touched) begin
      state_d.hold_button_flag = 1'b0;
    end

    // Pattern flag set and conditional clear
    if (pattern_cond) begin
      state_d.pattern_hit_flag = 1'b1;
    end else if (irq_clear) begin
      state_d.pattern_hit_flag = 1'b0;
    end

    // Touch bits stick until cleared and released
    if (irq_clear) begin
      state_d.touched = live_touch;
    end else begin
      state_d.touched = state_q.touched | live_touch;
    end

    // Deep sleep wipes status and pending
    if (pstate == touch_regs_pkg::PWR_DEEP) begin
      state_d.ctrl[`CTL_IRQ]   = 1'b0;
      state_d.base_limit_flag  = 1'b0;
      state_d.cal_failure_flag = 1'b0;
      state_d.hold_button_flag = 1'b0;
      state_d.multi_block_flag = 1'b0;
      state_d.pattern_hit_flag = 1'b0;
      state_d.touched          = '0;
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Read data is held between reads, so a slow host engine may pick it up late.
    // The cost is one byte of flip-flops that never goes idle.
    if (!reg_rd) begin
      state_d.rdata = state_q.rdata;
    end else if (reg_addr == `OFS_POWER_GAIN_CONTROL) begin
      state_d.rdata = state_q.ctrl;
    end else if (reg_addr == `OFS_GENERAL_EVENT_STATUS) begin
      state_d.rdata = gen_status;
    end else if (reg_addr == `OFS_INPUT_TOUCH_STATUS) begin
      state_d.rdata = input_status;
    end else begin
      state_d.rdata = 8'h00;
    end
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  // Reset defaults
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q <= '{ctrl: `RST_POWER_GAIN_CONTROL, rdata: `RST_STATUS, default: '0};
    end else begin
      state_q <= state_d;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign power_state   = pstate;
  assign scan_en       = scan;
  assign active_gain   = touch_regs_pkg::gain_of(state_q.ctrl[`CTL_GAIN_HI:`CTL_GAIN_LO]);
  assign standby_gain  = state_q.ctrl[`CTL_MIXED]
                       ? touch_regs_pkg::gain_of(state_q.ctrl[`CTL_SGAIN_HI:`CTL_SGAIN_LO])
                       : active_gain;
  assign recal_all     = state_q.recal;
  assign release_pulse = state_q.release_p;
  assign reg_rdata     = state_q.rdata;
  assign reg_rvalid    = state_q.rvalid;
  assign alert_n       = ~state_q.ctrl[`CTL_IRQ];

endmodule : touch_power_state_status_regs

// ### design/touch_regs_defines.svh
/*
 * Register offsets, field positions and reset values for the touch power and status bank.
 * Assumes it is included by its bare name from the design module.
 */
`ifndef TOUCH_REGS_DEFINES_SVH
`define TOUCH_REGS_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_POWER_GAIN_CONTROL   8'h00
`define OFS_GENERAL_EVENT_STATUS 8'h02
`define OFS_INPUT_TOUCH_STATUS   8'h03

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define CTL_GAIN_HI    7
`define CTL_GAIN_LO    6
`define CTL_STANDBY    5
`define CTL_DEEP_SLEEP 4
`define CTL_SGAIN_HI   3
`define CTL_SGAIN_LO   2
`define CTL_MIXED      1
`define CTL_IRQ        0

// ----------------------------------------------------------------------
// General status fields
// ----------------------------------------------------------------------
`define GST_BASE_LIMIT  6
`define GST_CAL_FAIL    5
`define GST_HOLD        4
`define GST_MULTI       2
`define GST_PATTERN     1
`define GST_ANY_TOUCH   0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_POWER_GAIN_CONTROL 8'h00
`define RST_STATUS             8'h00

`endif

// ### design/touch_regs_pkg.sv
/*
 * Types and the gain decode shared by the touch power and status bank.
 * Assumes the defines header is on the include path.
 */
package touch_regs_pkg;

  // --------------------------------------------------------------------
  // Power states
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    PWR_ACTIVE  = 2'b00,
    PWR_STANDBY = 2'b01,
    PWR_MIXED   = 2'b10,
    PWR_DEEP    = 2'b11
  } power_state_t;

  // --------------------------------------------------------------------
  // Gain selector to multiplier: 00..11 map to 1, 2, 4, 8.
  // --------------------------------------------------------------------
  function automatic logic [3:0] gain_of(input logic [1:0] sel);
    gain_of = 4'h1 << sel;
  endfunction : gain_of

endpackage : touch_regs_pkg

// ### dv/touch_regs_assertions.sv
/* Checker for the touch power and status bank, seeing only its top ports.
   Assumes it is bound to the bank, with mclk and resetn the bank's own. */
`timescale 1ns/1ns
module touch_regs_checker #(parameter int NUM_INPUTS = 3) (
  // Clock and reset
  input wire logic                          mclk,
  input wire logic                          resetn,
  // Register strobes and answers
  input wire logic [7:0]                    reg_addr,
  input wire logic [7:0]                    reg_wdata,
  input wire logic                          reg_wr,
  input wire logic                          reg_rd,
  input wire logic [7:0]                    reg_rdata,
  input wire logic                          reg_rvalid,
  // Front end and alert
  input wire touch_regs_pkg::power_state_t  power_state,
  input wire logic [NUM_INPUTS-1:0]         scan_en,
  input wire logic [3:0]                    active_gain,
  input wire logic [3:0]                    standby_gain,
  input wire logic                          recal_all,
  input wire logic [NUM_INPUTS-1:0]         release_pulse,
  input wire logic                          alert_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence ctl_wr_s; reg_wr && reg_addr == 8'h00; endsequence
  sequence deep_s; power_state == touch_regs_pkg::PWR_DEEP; endsequence
  // Deep sleep beats mixed, mixed beats standby.
  function automatic logic [1:0] st(input logic [7:0] w);
    st = w[4] ? 2'h3 : (w[1] ? 2'h2 : {1'b0, w[5]});
  endfunction : st
  state_prio_a: assert property (ctl_wr_s |=> power_state == st($past(reg_wdata)))
    else $error("power state not resolved from control write");
  gain_decode_a: assert property (ctl_wr_s |=> active_gain == 4'h1 << $past(reg_wdata[7:6]))
    else $error("primary gain decode wrong");
  sgain_decode_a: assert property (ctl_wr_s |=> standby_gain ==
    ($past(reg_wdata[1]) ? 4'h1 << $past(reg_wdata[3:2]) : 4'h1 << $past(reg_wdata[7:6])))
    else $error("secondary gain decode wrong");
  recal_cause_a: assert property (recal_all |-> $past(reg_wr) && $past(reg_addr) == 8'h00)
    else $error("recalibration without a control write");
  deep_scan_a: assert property (deep_s |-> scan_en == '0)
    else $error("scanning while in deep sleep");
  deep_alert_a: assert property (deep_s [*3] |-> alert_n)
    else $error("alert held in deep sleep");
  read_answer_a: assert property (1'b1 |-> reg_rvalid == $past(reg_rd))
    else $error("read answer not one cycle after strobe");
  unmapped_zero_a: assert property (reg_rd && !(reg_addr inside {8'h00, 8'h02, 8'h03})
    |=> reg_rdata == 8'h00) else $error("unmapped offset read nonzero");
  unused_zero_a: assert property (reg_rd && reg_addr == 8'h03 |=> reg_rdata[7:3] == 5'h00)
    else $error("unused touch status bits nonzero");
  release_once_a: assert property ($fell(scan_en[0]) |=> release_pulse[0])
    else $error("no release pulse when input left the scan");
endmodule : touch_regs_checker

bind touch_power_state_status_regs touch_regs_checker #(.NUM_INPUTS(NUM_INPUTS)) chk_u (
  .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .power_state(power_state), .scan_en(scan_en), .active_gain(active_gain),
  .standby_gain(standby_gain), .recal_all(recal_all), .release_pulse(release_pulse),
  .alert_n(alert_n));

// ### dv/smbus_host_model.sv
/* Host side of the register strobe port: one-byte writes and reads.
   Assumes the bank answers a read with rvalid one cycle after the strobe. */
`timescale 1ns/1ns
module smbus_host_model (
  // Clock
  input wire logic        mclk,
  // Strobes to the bank
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  // Answers from the bank
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid
);
  // Extra idle cycles before each access, to act as a slow host.
  int idle = 0;
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    repeat (idle) @(posedge mclk);
    @(posedge mclk);
    #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge mclk);
    #1 reg_wr = 1'b0;
    // Released lines show garbage, not the last value.
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    repeat (idle) @(posedge mclk);
    @(posedge mclk);
    #1 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge mclk);
    #1 reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rvalid ? reg_rdata : 8'hXX;
  endtask : rd
endmodule : smbus_host_model

// ### dv/touch_power_state_status_regs_tb_top.sv
/* Testbench for the touch power and status bank, driven through the host model.
   Assumes the checker is bound by its own file. */
`timescale 1ns/1ns
module touch_power_state_status_regs_tb_top;
  logic mclk, resetn, reg_wr, reg_rd, reg_rvalid, recal_all, alert_n;
  logic base_out_any, cal_fail_any, hold_event, hold_button_touched;
  logic multi_blocking, pattern_cond, pattern_irq_en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [2:0] active_en, standby_en, irq_en, touch_detect, scan_en, release_pulse;
  logic [3:0] active_gain, standby_gain;
  logic [1:0] st;
  logic [2:0] se;
  logic [2:0] sp = 3'h3;
  touch_regs_pkg::power_state_t power_state;
  int fails = 0;
  int checked = 0;
  logic [7:0] pw [8] = '{8'h00, 8'h20, 8'h02, 8'h22, 8'h10, 8'h30, 8'h12, 8'h32};

  touch_power_state_status_regs dut_u (.mclk(mclk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .active_en(active_en),
    .standby_en(standby_en), .irq_en(irq_en), .touch_detect(touch_detect),
    .base_out_any(base_out_any), .cal_fail_any(cal_fail_any), .hold_event(hold_event),
    .hold_button_touched(hold_button_touched), .multi_blocking(multi_blocking),
    .pattern_cond(pattern_cond), .pattern_irq_en(pattern_irq_en),
    .power_state(power_state), .scan_en(scan_en), .active_gain(active_gain),
    .standby_gain(standby_gain), .recal_all(recal_all), .release_pulse(release_pulse),
    .alert_n(alert_n));
  smbus_host_model host_u (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_u.rd(a, d);
    check(d, e);
  endtask : rdc
  task automatic settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask : settle
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // The whole sequence needs well under a thousand cycles.
  initial begin
    #20000;
    fails++;
    give_verdict;
  end
  initial begin
    {resetn, hold_event, hold_button_touched, multi_blocking} = 4'h0;
    {base_out_any, cal_fail_any, pattern_cond, pattern_irq_en} = 4'h0;
    {active_en, standby_en, irq_en, touch_detect} = 12'h788;
    touch_detect = 3'h0;
    repeat (5) @(posedge mclk);
    #1 resetn = 1'b1;
    repeat (3) @(posedge mclk);
    rdc(8'h00, 8'h00);
    rdc(8'h02, 8'h00);
    rdc(8'h01, 8'h00);
    host_u.wr(8'h03, 8'hFF);
    rdc(8'h03, 8'h00);
    foreach (pw[i]) begin
      host_u.wr(8'h00, pw[i]);
      st = pw[i][4] ? 2'h3 : (pw[i][1] ? 2'h2 : {1'b0, pw[i][5]});
      se = st == 2'h3 ? 3'h0 : (st == 2'h2 ? 3'h7 : (st[0] ? 3'h6 : 3'h3));
      check(power_state, st);
      check(scan_en, se);
      @(posedge mclk);
      #1 check(release_pulse, sp & ~se);
      sp = se;
      rdc(8'h00, pw[i]);
    end
    for (int g = 0; g < 4; g++) begin
      host_u.wr(8'h00, 8'((g << 6) | ((3 - g) << 2) | 2));
      check(recal_all, 1'b1);
      check(active_gain, 4'h1 << g);
      check(standby_gain, 4'h1 << (3 - g));
    end
    host_u.wr(8'h00, 8'hC0);
    check(recal_all, 1'b0);
    check(standby_gain, 4'h8);
    host_u.wr(8'h00, 8'h00);
    touch_detect = 3'h1;
    settle;
    check(alert_n, 1'b0);
    rdc(8'h03, 8'h01);
    rdc(8'h02, 8'h01);
    host_u.wr(8'h00, 8'h00);
    check(alert_n, 1'b1);
    rdc(8'h03, 8'h01);
    touch_detect = 3'h0;
    host_u.wr(8'h00, 8'h00);
    rdc(8'h03, 8'h00);
    touch_detect = 3'h2;
    settle;
    check(alert_n, 1'b1);
    touch_detect = 3'h0;
    host_u.wr(8'h00, 8'h00);
    hold_button_touched = 1'b1;
    hold_event = 1'b1;
    @(posedge mclk);
    #1 hold_event = 1'b0;
    settle;
    check(alert_n, 1'b0);
    host_u.wr(8'h00, 8'h00);
    rdc(8'h02, 8'h10);
    hold_button_touched = 1'b0;
    host_u.wr(8'h00, 8'h00);
    rdc(8'h02, 8'h00);
    pattern_cond = 1'b1;
    settle;
    check(alert_n, 1'b1);
    rdc(8'h02, 8'h02);
    pattern_cond = 1'b0;
    host_u.wr(8'h00, 8'h00);
    rdc(8'h02, 8'h00);
    pattern_irq_en = 1'b1;
    pattern_cond = 1'b1;
    settle;
    check(alert_n, 1'b0);
    pattern_cond = 1'b0;
    host_u.wr(8'h00, 8'h00);
    {multi_blocking, base_out_any, cal_fail_any} = 3'h7;
    settle;
    rdc(8'h02, 8'h64);
    check(alert_n, 1'b1);
    base_out_any = 1'b0;
    settle;
    rdc(8'h02, 8'h24);
    {multi_blocking, cal_fail_any} = 2'h0;
    settle;
    rdc(8'h02, 8'h00);
    touch_detect = 3'h1;
    base_out_any = 1'b1;
    host_u.idle = 2;
    settle;
    host_u.wr(8'h00, 8'h10);
    settle;
    check(alert_n, 1'b1);
    rdc(8'h03, 8'h00);
    rdc(8'h02, 8'h00);
    give_verdict;
  end
endmodule : touch_power_state_status_regs_tb_top
